// file: hw/hrsm_regs.svh
// Purpose: constants for the hub repeater state machine
// Assumes: 20 MHz local clock
// Notes:   clock period in ns, bit times in ps, cycles derived
`ifndef HRSM_REGS_SVH
`define HRSM_REGS_SVH
`define HRSM_CLK_PERIOD_NS   50
// one full-speed bit time is 83.3 ns; low-speed is 666.7 ns (in ps to keep integers)
`define HRSM_FS_BIT_PS       83334
`define HRSM_LS_BIT_PS       666667
`define HRSM_FS_J_CYC        (((`HRSM_FS_BIT_PS) + (`HRSM_CLK_PERIOD_NS*1000) - 1) / (`HRSM_CLK_PERIOD_NS*1000))
`define HRSM_LS_J_CYC        (((`HRSM_LS_BIT_PS) + (`HRSM_CLK_PERIOD_NS*1000) - 1) / (`HRSM_CLK_PERIOD_NS*1000))
`define HRSM_PORT_COUNT      4
`endif

// file: hw/hrsm_pkg.sv
// Purpose: types for the hub repeater state machine
// Assumes: nothing
// Notes:   state enum and grouped event carriers
package hrsm_pkg;
  typedef enum logic [1:0] {
    WAIT_START_FROM_UPSTREAM,
    WAIT_END_FROM_UPSTREAM,
    WAIT_START_ANY_PORT,
    WAIT_END_DOWNSTREAM
  } hrsm_state_e;

  // receiver and frame timer indications
  typedef struct packed {
    logic rx_bus_reset;
    logic rx_suspend;
    logic rx_resume;
    logic first_frame_end_point;
    logic second_frame_end_point;
    logic frame_lock;
  } hrsm_ctl_s;
endpackage : hrsm_pkg

// file: hw/hrsm_repeater.sv
// Purpose: hub repeater control state machine
// Assumes: receiver, frame timer, port selector inputs are on clock domain
// Notes:   line-level idle/K/J inputs come from pins and are synchronised
//
// Operation
// - full/low speed: connect on start, release on end
// - fs/ls end transitions wait after one J bit
// - fs/ls start transitions act at J-to-K edge
// - hs end is OR of three sources
// - upstream end on upstream eop; downstream on send-idle
// - frame end points held until frame end
// - downstream start on idle-to-K, hs after valid
// - upstream start on idle-to-K, hs after valid
// - paths into wait start from upstream
// - wait start upstream: upstream start only, no links
// - paths into wait end from upstream
// - entering wait end upstream drives all enabled ports
// - paths into wait start any port
// - wait start any port: watch all, no links
// - downstream start connects port upstream, transmitter active
// - second point in wait end downstream: babble disable
// - first point ends upstream packet, stay waiting (eop sent in fs/ls only, not hs)
// - hs: connect on valid start, release on hs end
// - hs end transition after buffer last bit
`timescale 1ns/1ps
`include "hrsm_regs.svh"

module hrsm_repeater
  import hrsm_pkg::*;
#(
  parameter int NPORT = `HRSM_PORT_COUNT
)(
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire hrsm_ctl_s         ctl,
  input  wire logic              high_speed,
  input  wire logic              low_speed_port,
  input  wire logic [NPORT-1:0]  port_enabled,
  input  wire logic              up_line_k,
  input  wire logic [NPORT:0]    dn_line_k,
  input  wire logic              up_eop_seen,
  input  wire logic              tx_send_idle_state,
  input  wire logic              up_hs_packet_start_valid,
  input  wire logic [NPORT:0]    dn_hs_packet_start_valid,
  input  wire logic              buffer_drained,
  input  wire logic              send_resume_end_state_interval_end,
  input  wire logic              resume_interval_end,
  output logic [1:0]             state_code,
  output logic                   up_connect,
  output logic [NPORT-1:0]       dn_transmit,
  output logic [NPORT:0]         dn_connect,
  output logic                   up_tx_active,
  output logic                   up_tx_send_eop,
  output logic [NPORT-1:0]       babble_disable
);

  localparam int FS_J_CYC = `HRSM_FS_J_CYC;
  localparam int LS_J_CYC = `HRSM_LS_J_CYC;
  localparam int JW       = 5;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [NPORT+1:0] sync1_q;
  logic [NPORT+1:0] sync2_q;
  logic [NPORT+1:0] sync3_q;
  logic [NPORT+1:0] line_k_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_q  <= '0;
      sync2_q  <= '0;
      sync3_q  <= '0;
      line_k_q <= '0;
    end
    else
    begin
      sync1_q <= {dn_line_k, up_line_k};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      // change counts only once second and third stage agree
      for (int i = 0; i < NPORT + 2; i++)
        if (sync2_q[i] == sync3_q[i])
          line_k_q[i] <= sync3_q[i];
    end
  end

  // ************************************************************
  // start and end events
  // ************************************************************
  logic             up_k_d1_q;
  logic [NPORT:0]   dn_k_d1_q;
  logic             start_from_upstream;
  logic [NPORT:0]   start_from_downstream;
  logic             hs_packet_end_event;
  logic             upstream_end_event;
  logic             downstream_end_event;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      up_k_d1_q <= 1'b0;
      dn_k_d1_q <= '0;
    end
    else
    begin
      up_k_d1_q <= line_k_q[0];
      dn_k_d1_q <= line_k_q[NPORT+1:1];
    end
  end

  function automatic logic start_edge(input logic hs, input logic valid,
                                      input logic k_now, input logic k_was);
    // hs waits on a validated start; fs/ls acts on the first K edge
    start_edge = hs ? valid : (k_now & ~k_was);
  endfunction : start_edge

  assign start_from_upstream = start_edge(high_speed, up_hs_packet_start_valid,
                                          line_k_q[0], up_k_d1_q);

  genvar g;
  generate
    for (g = 0; g <= NPORT; g++)
    begin : g_dn_start
      logic en;
      // index NPORT is the hub controller, always enabled
      if (g < NPORT)
      begin : g_port
        assign en = port_enabled[g];
      end
      else
      begin : g_ctrl
        assign en = 1'b1;
      end
      assign start_from_downstream[g] = en & start_edge(high_speed,
        dn_hs_packet_start_valid[g], line_k_q[g+1], dn_k_d1_q[g]);
    end
  endgenerate

  assign hs_packet_end_event = buffer_drained | send_resume_end_state_interval_end
                             | resume_interval_end;

  // ************************************************************
  // fs/ls end deferral: one J bit after SE0-to-J
  // ************************************************************
  logic [JW-1:0] j_cnt_q;
  logic          up_end_pend_q;
  logic          dn_end_pend_q;
  logic          up_end_raw;
  logic          dn_end_raw;
  logic          pend_done;

  assign up_end_raw = high_speed ? hs_packet_end_event : up_eop_seen;
  assign dn_end_raw = high_speed ? hs_packet_end_event : tx_send_idle_state;
  assign pend_done  = (j_cnt_q == JW'(1));
  // an end arriving during the countdown is dropped; bus ends are far apart

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      j_cnt_q       <= '0;
      up_end_pend_q <= 1'b0;
      dn_end_pend_q <= 1'b0;
    end
    else if (ctl.rx_bus_reset)
    begin
      j_cnt_q       <= '0;
      up_end_pend_q <= 1'b0;
      dn_end_pend_q <= 1'b0;
    end
    else if (!high_speed && (up_end_raw || dn_end_raw) && j_cnt_q == '0)
    begin
      // J is driven for a full bit at the port's speed before acting
      j_cnt_q       <= low_speed_port ? JW'(LS_J_CYC) : JW'(FS_J_CYC);
      up_end_pend_q <= up_end_raw;
      dn_end_pend_q <= dn_end_raw;
    end
    else if (j_cnt_q != '0)
    begin
      j_cnt_q <= j_cnt_q - JW'(1);
      if (pend_done)
      begin
        up_end_pend_q <= 1'b0;
        dn_end_pend_q <= 1'b0;
      end
    end
  end

  // hs end sources already mark the last buffered bit repeated
  assign upstream_end_event   = high_speed ? up_end_raw : (pend_done & up_end_pend_q);
  assign downstream_end_event = high_speed ? dn_end_raw : (pend_done & dn_end_pend_q);

  // ************************************************************
  // repeater state machine
  // ************************************************************
  hrsm_state_e      state_q;
  hrsm_state_e      state_d;
  logic [NPORT:0]   src_q;
  logic [NPORT:0]   src_d;
  logic [NPORT:0]   first_dn;

  // lowest-numbered port wins if two start together
  assign first_dn = start_from_downstream & (~start_from_downstream + (NPORT+1)'(1));

  always_comb
  begin
    state_d = state_q;
    src_d   = src_q;
    case (state_q)
      WAIT_START_FROM_UPSTREAM:
      begin
        // downstream activity ignored here
        if (ctl.rx_resume || start_from_upstream)
          state_d = WAIT_END_FROM_UPSTREAM;
        else if (ctl.rx_suspend)
          state_d = WAIT_START_ANY_PORT;
      end
      WAIT_END_FROM_UPSTREAM:
      begin
        // resume is repeated down until the receiver leaves it
        if (ctl.rx_suspend)
          state_d = WAIT_START_ANY_PORT;
        else if (ctl.rx_resume)
          state_d = WAIT_END_FROM_UPSTREAM;
        else if (upstream_end_event)
          state_d = ctl.frame_lock ? WAIT_START_ANY_PORT
                                   : WAIT_START_FROM_UPSTREAM;
      end
      WAIT_START_ANY_PORT:
      begin
        if (ctl.rx_resume || start_from_upstream)
          state_d = WAIT_END_FROM_UPSTREAM;
        else if (ctl.first_frame_end_point)
          state_d = WAIT_START_FROM_UPSTREAM;
        else if (|start_from_downstream)
        begin
          state_d = WAIT_END_DOWNSTREAM;
          src_d   = first_dn;
        end
      end
      WAIT_END_DOWNSTREAM:
      begin
        if (ctl.rx_resume)
          state_d = WAIT_END_FROM_UPSTREAM;
        else if (ctl.second_frame_end_point)
          state_d = WAIT_START_FROM_UPSTREAM;
        else if (downstream_end_event)
          state_d = WAIT_START_ANY_PORT;
        if (state_d != WAIT_END_DOWNSTREAM)
          src_d = '0;
      end
      default:
      begin
        state_d = WAIT_START_FROM_UPSTREAM;
        src_d   = '0;
      end
    endcase
    if (ctl.rx_bus_reset)
    begin
      state_d = WAIT_START_FROM_UPSTREAM;
      src_d   = '0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= WAIT_START_FROM_UPSTREAM;
      src_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      src_q   <= src_d;
    end
  end

  // ************************************************************
  // connectivity outputs, all registered from next state
  // ************************************************************
  // same decode drives both downstream-directed outputs
  function automatic logic down_link(input hrsm_state_e s);
    down_link = (s == WAIT_END_FROM_UPSTREAM);
  endfunction : down_link

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_code   <= 2'h0;
      up_connect   <= 1'b0;
      dn_transmit  <= '0;
      dn_connect   <= '0;
      up_tx_active <= 1'b0;
    end
    else
    begin
      state_code   <= 2'(state_d);
      up_connect   <= down_link(state_d);
      dn_transmit  <= down_link(state_d) ? port_enabled : '0;
      dn_connect   <= src_d;
      up_tx_active <= (state_d == WAIT_END_DOWNSTREAM);
    end
  end

  // ************************************************************
  // frame end handling in wait end downstream
  // ************************************************************
  logic fep1_d1_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fep1_d1_q      <= 1'b0;
      up_tx_send_eop <= 1'b0;
    end
    else
    begin
      fep1_d1_q      <= ctl.first_frame_end_point;
      // one-cycle request at the rising first point; state is kept
      // no request if the device ends its packet on that same edge
      up_tx_send_eop <= ctl.first_frame_end_point & ~fep1_d1_q & ~high_speed
                      & (state_q == WAIT_END_DOWNSTREAM)
                      & (state_d == WAIT_END_DOWNSTREAM);
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      babble_disable <= '0;
    end
    else
    begin
      // one cycle only: the state leaves on the same edge
      babble_disable <= (state_q == WAIT_END_DOWNSTREAM && ctl.second_frame_end_point
                         && !ctl.rx_bus_reset && !ctl.rx_resume)
                        ? src_q[NPORT-1:0] : '0;
    end
  end

endmodule : hrsm_repeater

// file: verification/hrsm_far_end.sv
// Purpose: far side model, host and devices
// Assumes: events are one-cycle pulses, except line K, held until send-idle
// Notes:   dly gives prompt or slow answers
`timescale 1ns/1ps
module hrsm_far_end (
  input  wire logic clock,
  output logic       up_start,
  output logic [4:0] dn_start,
  output logic [2:0] hs_end,
  output logic [4:0] dn_k,
  output logic       tx_idle
);
  initial {up_start, dn_start, hs_end, dn_k, tx_idle} = '0;
  // k: 0 up start, 1 dn start, 2 hs end, 3 dn line K, 4 send-idle
  task automatic ev(input int k, input int i, input int dly);
    repeat (dly) @(posedge clock);
    #2;
    case (k)
      0: up_start = 1'b1;
      1: dn_start[i] = 1'b1;
      2: hs_end[i] = 1'b1;
      3: dn_k[i] = 1'b1;
      default: tx_idle = 1'b1;
    endcase
    @(posedge clock);
    #2;
    {up_start, dn_start, hs_end, tx_idle} = '0;
    // line K held until the packet ends
    if (k == 4) dn_k = '0;
  endtask : ev
endmodule : hrsm_far_end

// file: verification/hrsm_repeater_assertions.sv
// Purpose: port checks of the repeater state machine
// Assumes: one clock, reset active high
// Notes:   hs paths checked exactly except the downstream end (cover only), fs only loosely
`timescale 1ns/1ps
module hrsm_repeater_assertions
  import hrsm_pkg::*;
#(
  parameter int NPORT = 4
)(
  input wire logic             clock,
  input wire logic             sys_rst,
  input wire hrsm_ctl_s        ctl,
  input wire logic             high_speed,
  input wire logic [NPORT-1:0] port_enabled,
  input wire logic             up_hs_packet_start_valid,
  input wire logic [NPORT:0]   dn_hs_packet_start_valid,
  input wire logic             buffer_drained,
  input wire logic             send_resume_end_state_interval_end,
  input wire logic             resume_interval_end,
  input wire logic [1:0]       state_code,
  input wire logic             up_connect,
  input wire logic [NPORT-1:0] dn_transmit,
  input wire logic [NPORT:0]   dn_connect,
  input wire logic             up_tx_active,
  input wire logic             up_tx_send_eop,
  input wire logic [NPORT-1:0] babble_disable
);
  logic           quiet;
  logic           hs_end;
  logic [NPORT:0] dn_req;
  logic [NPORT:0] dn_low;
  assign quiet  = !ctl.rx_bus_reset && !ctl.rx_suspend && !ctl.rx_resume;
  assign hs_end = buffer_drained | send_resume_end_state_interval_end | resume_interval_end;
  assign dn_req = dn_hs_packet_start_valid & {1'b1, port_enabled};
  // lowest index wins a tie
  assign dn_low = dn_req & (~dn_req + (NPORT+1)'(1));
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_bus_reset_wins: assert property (ctl.rx_bus_reset |=> state_code == 2'h0)
    else $error("bus reset missed");
  a_idle_no_link: assert property (state_code == 2'h0 |-> !up_connect && dn_connect == '0)
    else $error("link while idle");
  a_up_start_links: assert property (quiet && high_speed && up_hs_packet_start_valid
    && !state_code[0] |=> state_code == 2'h1 && up_connect && dn_transmit == $past(port_enabled))
    else $error("upstream start wrong");
  a_resume_entry: assert property (ctl.rx_resume && !ctl.rx_bus_reset && !ctl.rx_suspend
    |=> state_code == 2'h1) else $error("resume entry wrong");
  a_suspend_entry: assert property (ctl.rx_suspend && !ctl.rx_resume && !ctl.rx_bus_reset
    && !state_code[1] |=> state_code == 2'h2) else $error("suspend entry wrong");
  a_hs_end_up: assert property (quiet && high_speed && hs_end && state_code == 2'h1
    |=> state_code == ($past(ctl.frame_lock) ? 2'h2 : 2'h0)) else $error("upstream end wrong");
  a_first_point: assert property (quiet && state_code == 2'h2 && ctl.first_frame_end_point
    && !up_hs_packet_start_valid |=> state_code == 2'h0) else $error("first point wrong");
  a_dn_start_link: assert property (quiet && high_speed && state_code == 2'h2 && dn_req != '0
    && !up_hs_packet_start_valid && !ctl.first_frame_end_point
    |=> state_code == 2'h3 && up_tx_active && dn_connect == $past(dn_low))
    else $error("downstream start wrong");
  a_second_point: assert property (quiet && state_code == 2'h3 && ctl.second_frame_end_point
    |=> state_code == 2'h0) else $error("second point wrong");
  a_babble_cause: assert property ($rose(|babble_disable) |-> $onehot(babble_disable)
    && $past(state_code) == 2'h3 && $past(ctl.second_frame_end_point))
    else $error("babble without cause");
  a_eop_pulse: assert property (up_tx_send_eop |-> state_code == 2'h3 ##1 !up_tx_send_eop)
    else $error("eop pulse wrong");
  c_dn_done: cover property (state_code == 2'h3 ##1 state_code == 2'h2);
  c_babble: cover property (|babble_disable);
  c_eop: cover property (up_tx_send_eop);
endmodule : hrsm_repeater_assertions

// file: verification/testbench.sv
// Purpose: self-checking bench of the repeater state machine
// Assumes: default port count of four
// Notes:   fs start passes a synchroniser, so waits are bounded
`timescale 1ns/1ps
module testbench;
  import hrsm_pkg::*;
  logic       clock;
  logic       sys_rst;
  hrsm_ctl_s  ctl;
  logic       high_speed;
  logic       low_speed_port;
  logic [3:0] port_enabled;
  logic       up_line_k;
  logic [4:0] dn_line_k;
  logic       up_eop_seen;
  logic       tx_send_idle_state;
  logic       up_hs_packet_start_valid;
  logic [4:0] dn_hs_packet_start_valid;
  logic [2:0] hs_end;
  logic [1:0] state_code;
  logic       up_connect;
  logic [3:0] dn_transmit;
  logic [4:0] dn_connect;
  logic       up_tx_active;
  logic       up_tx_send_eop;
  logic [3:0] babble_disable;
  int         fail_count = 0;
  int         checks_done = 0;
  int         cyc = 0;
  int         seed, est, p, pe, lk;
  int         portq[$];
  int         cbit[4] = '{4, 2, 3, 5};
  int         cnext[4] = '{2, 0, 1, 0};
  hrsm_repeater dut (.clock, .sys_rst, .ctl, .high_speed, .low_speed_port, .port_enabled,
    .up_line_k, .dn_line_k, .up_eop_seen, .tx_send_idle_state, .up_hs_packet_start_valid,
    .dn_hs_packet_start_valid, .buffer_drained(hs_end[0]),
    .send_resume_end_state_interval_end(hs_end[1]), .resume_interval_end(hs_end[2]),
    .state_code, .up_connect, .dn_transmit, .dn_connect, .up_tx_active, .up_tx_send_eop,
    .babble_disable);
  hrsm_far_end far (.clock, .up_start(up_hs_packet_start_valid),
    .dn_start(dn_hs_packet_start_valid), .hs_end, .dn_k(dn_line_k),
    .tx_idle(tx_send_idle_state));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // hang guard, generous against some 100 cycles of tests
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step();
    @(posedge clock);
    #2;
  endtask : step
  task automatic cp(input int b);
    ctl[b] = 1'b1;
    step();
    ctl[b] = 1'b0;
  endtask : cp
  task automatic wst(input int n);
    for (int i = 0; i < n && state_code !== est[1:0]; i++) step();
    chk(state_code, est[1:0]);
  endtask : wst
  initial
  begin
    seed = 8532;
    sys_rst = 1'b1;
    ctl = '0;
    high_speed = 1'b1;
    low_speed_port = 1'b0;
    port_enabled = 4'hF;
    up_line_k = 1'b0;
    up_eop_seen = 1'b0;
    repeat (10) @(posedge clock);
    #2;
    sys_rst = 1'b0;
    est = 0;
    chk(state_code, est[1:0]);
    for (int k = 0; k < 3; k++)
    begin
      pe = $random(seed);
      lk = $random(seed);
      port_enabled = pe[3:0];
      ctl.frame_lock = lk[0];
      far.ev(0, 0, 1 + k);
      est = 1;
      chk(state_code, est[1:0]);
      chk(dn_transmit, pe[3:0]);
      chk(up_connect, 1'b1);
      far.ev(2, k, 1);
      est = lk[0] ? 2 : 0;
      chk(state_code, est[1:0]);
      chk(up_connect, 1'b0);
    end
    $display("test upstream done");
    port_enabled = 4'hF;
    cp(5);
    far.ev(1, 2, 1);
    est = 0;
    chk(state_code, est[1:0]);
    chk(dn_connect, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      cp(4);
      est = 2;
      chk(state_code, est[1:0]);
      p = $random(seed) & 3;
      portq.push_back(p);
      far.ev(1, p, 2);
      est = 3;
      chk(state_code, est[1:0]);
      chk(dn_connect, 8'h01 << p);
      chk(up_tx_active, 1'b1);
      if (k == 0)
      begin
        far.ev(2, 1, 1);
        est = 2;
      end
      else
      begin
        cp(1);
        est = 0;
      end
      chk(state_code, est[1:0]);
      chk(babble_disable, k ? 8'h01 << portq.pop_back() : 8'h00);
    end
    $display("test downstream done");
    foreach (cbit[i])
    begin
      cp(cbit[i]);
      est = cnext[i];
      chk(state_code, est[1:0]);
    end
    $display("test receiver done");
    high_speed = 1'b0;
    cp(4);
    far.ev(3, p, 1);
    est = 3;
    wst(8);
    ctl.first_frame_end_point = 1'b1;
    lk = 0;
    repeat (3)
    begin
      step();
      lk += up_tx_send_eop;
    end
    ctl.first_frame_end_point = 1'b0;
    chk(lk, 1);
    chk(state_code, est[1:0]);
    far.ev(4, 0, 1);
    chk(state_code, est[1:0]);
    est = 2;
    wst(20);
    low_speed_port = 1'b1;
    ctl.frame_lock = 1'b0;
    up_line_k = 1'b1;
    est = 1;
    wst(8);
    chk(dn_transmit, 8'h0F);
    up_line_k = 1'b0;
    up_eop_seen = 1'b1;
    step();
    up_eop_seen = 1'b0;
    // ls J hold rounds up to 14 cycles after the sampled end
    repeat (12) step();
    chk(state_code, est[1:0]);
    est = 0;
    wst(4);
    $display("test full speed done");
    results();
  end
endmodule : testbench
bind hrsm_repeater hrsm_repeater_assertions #(.NPORT(NPORT)) u_chk (.clock, .sys_rst, .ctl,
  .high_speed, .port_enabled, .up_hs_packet_start_valid, .dn_hs_packet_start_valid,
  .buffer_drained, .send_resume_end_state_interval_end, .resume_interval_end, .state_code,
  .up_connect, .dn_transmit, .dn_connect, .up_tx_active, .up_tx_send_eop, .babble_disable);
